// ---- src/cgc_top.sv ----
`default_nettype none
module cgc_top #(
  parameter int SETTLE = cgc_pkg::SETTLE_CYC
) (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  // axi4-lite write address, data and response
  input  wire logic [cgc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [cgc_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read
  input  wire logic [cgc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [cgc_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // oscillator and wake pins
  input  wire logic                        mainOscRunning,
  input  wire logic                        pllLocked,
  input  wire logic                        lowSpeedClk,
  input  wire logic                        wakeRequest,
  // clock controls
  output logic                             mainOscEnable,
  output logic                             pllEnable,
  output logic                             pllSelfRun,
  output logic [cgc_pkg::MULT_W-1:0]       pllMultiplier,
  output logic [cgc_pkg::DIV_W-1:0]        baseDivide,
  output logic [cgc_pkg::DIV_W-1:0]        periphDivide,
  output logic                             baseClockSourceSelect,
  output logic                             lowSpeedSelect,
  output logic                             pllSourceSelected,
  output logic                             clockOut,
  // power mode and interrupt
  output logic                             waitMode,
  output logic                             stopMode,
  output logic                             irq
);
  import cgc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage is read only by the second
  logic [3:0] pinMeta_r;
  logic [3:0] pinSync_r;
  always_ff @(posedge clock)
  begin
    pinMeta_r <= {wakeRequest, lowSpeedClk, pllLocked, mainOscRunning};
    pinSync_r <= pinMeta_r;
  end
  wire mainRunSync = pinSync_r[0];
  wire pllLockSync = pinSync_r[1];
  wire lowClkSync  = pinSync_r[2];
  wire wakeSync    = pinSync_r[3];

  cgc_stab_if mainStab ();
  cgc_stab_if pllStab ();
  assign mainStab.level = mainRunSync;
  assign pllStab.level  = pllLockSync;

  cgc_stab_timer #(.CYCLES(SETTLE)) uMainStab (
    .clock   (clock),
    .sys_rst (sys_rst),
    .port    (mainStab)
  );
  cgc_stab_timer #(.CYCLES(SETTLE)) uPllStab (
    .clock   (clock),
    .sys_rst (sys_rst),
    .port    (pllStab)
  );

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic              awHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic              wHeld_r;
  logic [31:0]       wData_r;
  logic [3:0]        wStrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  assign s_axi_awready = !awHeld_r && !bvalid_r;
  assign s_axi_wready  = !wHeld_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  wire doWrite = awHeld_r && wHeld_r && !bvalid_r;
  wire doRead  = s_axi_arvalid && !rvalid_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nu,
                                        input logic [3:0] strb);
    logic [31:0] mask;
    mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~mask) | (nu & mask);
  endfunction

  logic [31:0] ctrlA_r;
  logic [31:0] ctrlB_r;
  logic [31:0] srcCtrl_r;
  logic [31:0] pmodeC_r;
  logic [31:0] wprot_r;
  logic        pllSelf_r;
  logic [MULT_W-1:0] pllMult_r;
  logic [IRQ_W-1:0]  irqStat_r;
  logic [IRQ_W-1:0]  irqMask_r;
  cgc_pmode_t        pmode_r;
  cgc_pmode_t        pmode_nxt;

  wire wrCtrlA   = doWrite && (awAddr_r == OFS_CTRL_A);
  wire wrCtrlB   = doWrite && (awAddr_r == OFS_CTRL_B);
  wire wrSrc     = doWrite && (awAddr_r == OFS_SRC_CTRL);
  wire wrPmodeC  = doWrite && (awAddr_r == OFS_PMODE_C);
  wire wrWprot   = doWrite && (awAddr_r == OFS_WPROT);
  wire wrPllB    = doWrite && (awAddr_r == OFS_PLL_B);
  wire wrPllA    = doWrite && (awAddr_r == OFS_PLL_A);
  wire wrIrqStat = doWrite && (awAddr_r == OFS_IRQ_STAT);
  wire wrIrqMask = doWrite && (awAddr_r == OFS_IRQ_MASK);
  wire wrPower   = doWrite && (awAddr_r == OFS_POWER);
  wire wrStatus  = doWrite && (awAddr_r == OFS_STATUS);
  wire wrMapped  = wrCtrlA || wrCtrlB || wrSrc || wrPmodeC || wrWprot || wrPllB
                   || wrPllA || wrIrqStat || wrIrqMask || wrPower || wrStatus;

  wire [31:0] newCtrlA  = merge(ctrlA_r, wData_r, wStrb_r);
  wire [31:0] newCtrlB  = merge(ctrlB_r, wData_r, wStrb_r);
  wire [31:0] newSrc    = merge(srcCtrl_r, wData_r, wStrb_r);
  wire [31:0] newPmodeC = merge(pmodeC_r, wData_r, wStrb_r);
  wire [31:0] newWprot  = merge(wprot_r, wData_r, wStrb_r);
  wire [31:0] pllBOld   = {31'h0000_0000, pllSelf_r};
  wire [31:0] pllAOld   = {{(32 - MULT_W){1'b0}}, pllMult_r};
  wire [31:0] newPllB   = merge(pllBOld, wData_r, wStrb_r);
  wire [31:0] newPllA   = merge(pllAOld, wData_r, wStrb_r);
  wire [31:0] irqW1c    = merge(32'h0000_0000, wData_r, wStrb_r);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
      awAddr_r <= '0;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock control registers
  wire clkUnlock = wprot_r[WP_CLK];
  wire pllUnlock = wprot_r[WP_PLL];
  // a stopped reference leaves the multiplier frozen, self-run reset included
  wire pllFrozen = !mainStab.stable || !ctrlB_r[CB_PLL_EN];
  wire selfSet   = wrPllB && newPllB[PB_SELF] && !pllFrozen;
  // enforced in hardware too: a multiplier write retunes the pll only with WP_PLL set, the pll enabled, its source selected and the reference settled
  wire pllAOk    = wrPllA && pllUnlock && !srcCtrl_r[CS_SRC] && !pllFrozen;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ctrlA_r   <= CTRL_A_RST;
      ctrlB_r   <= CTRL_B_RST;
      srcCtrl_r <= SRC_CTRL_RST;
      pmodeC_r  <= PMODE_C_RST;
      wprot_r   <= WPROT_RST;
      pllSelf_r <= 1'b0;
      pllMult_r <= PLL_A_RST;
      irqMask_r <= '0;
    end
    else
    begin
      if (wrCtrlA)
        ctrlA_r <= newCtrlA;
      if (wrCtrlB)
        ctrlB_r <= newCtrlB;
      if (wrSrc)
        srcCtrl_r <= newSrc;
      if (wrPmodeC && clkUnlock)
        pmodeC_r <= newPmodeC;
      if (wrWprot)
        wprot_r <= newWprot;
      if (wrPllB)
        pllSelf_r <= newPllB[PB_SELF];
      if (selfSet)
        pllMult_r <= PLL_A_RST;
      else if (pllAOk)
        pllMult_r <= newPllA[MULT_W-1:0];
      if (wrIrqMask)
        irqMask_r <= irqW1c[IRQ_W-1:0];
    end
  end

  assign mainOscEnable         = !ctrlA_r[CA_OSC_DIS];
  assign pllEnable             = ctrlB_r[CB_PLL_EN];
  assign baseClockSourceSelect = ctrlB_r[CB_BCS];
  assign lowSpeedSelect        = ctrlB_r[CB_LS_SEL];
  assign pllSourceSelected     = !srcCtrl_r[CS_SRC];
  assign baseDivide            = srcCtrl_r[CS_BDIV_LSB +: DIV_W];
  assign periphDivide          = pmodeC_r[PM_PDIV_LSB +: DIV_W];
  assign pllSelfRun            = pllSelf_r;
  assign pllMultiplier         = pllMult_r;

  ////////////////////////////////////////////////////////////////////////////
  // clock output pin
  wire [COUT_W-1:0] coutSel = ctrlA_r[CA_COUT_LSB +: COUT_W];
  logic             clockOut_r;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      clockOut_r <= 1'b0;
    else
      clockOut_r <= (coutSel == COUT_LOW) && lowClkSync;
  end
  assign clockOut = clockOut_r;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator events and interrupt
  wire              oscStatus = !mainStab.stable;
  logic             mainStablePrev_r;
  logic             mainRunPrev_r;
  wire [IRQ_W-1:0]  events;
  assign events[EV_OSC_STOP]  = mainRunPrev_r && !mainRunSync;
  assign events[EV_OSC_READY] = mainStab.stable && !mainStablePrev_r;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      mainRunPrev_r    <= 1'b0;
      mainStablePrev_r <= 1'b0;
      irqStat_r        <= '0;
    end
    else
    begin
      mainRunPrev_r    <= mainRunSync;
      mainStablePrev_r <= mainStab.stable;
      // a new event beats a clear in the same cycle
      irqStat_r <= (irqStat_r & ~(wrIrqStat ? irqW1c[IRQ_W-1:0] : '0)) | events;
    end
  end
  assign irq = |(irqStat_r & irqMask_r);

  ////////////////////////////////////////////////////////////////////////////
  // power modes: software request enters, a wake pin returns to normal
  always_comb
  begin
    pmode_nxt = pmode_r;
    case (pmode_r)
      PM_NORMAL:
        if (wrPower && wData_r[PW_STOP])
          pmode_nxt = PM_STOP;
        else if (wrPower && wData_r[PW_WAIT])
          pmode_nxt = PM_WAIT;
      PM_WAIT, PM_STOP:
        if (wakeSync)
          pmode_nxt = PM_NORMAL;
      default:
        pmode_nxt = PM_NORMAL;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pmode_r <= PM_NORMAL;
    else
      pmode_r <= pmode_nxt;
  end
  assign waitMode = (pmode_r == PM_WAIT);
  assign stopMode = (pmode_r == PM_STOP);

  ////////////////////////////////////////////////////////////////////////////
  // read path
  logic [31:0] rdMux;
  logic        rdHit;
  always_comb
  begin
    rdHit = 1'b1;
    rdMux = 32'h0000_0000;
    case (s_axi_araddr)
      OFS_CTRL_A:   rdMux = ctrlA_r;
      OFS_CTRL_B:   rdMux = ctrlB_r;
      OFS_SRC_CTRL: rdMux = srcCtrl_r;
      OFS_PMODE_C:  rdMux = pmodeC_r;
      OFS_WPROT:    rdMux = wprot_r;
      OFS_PLL_B:    rdMux = pllBOld;
      OFS_PLL_A:    rdMux = pllAOld;
      OFS_STATUS:
      begin
        rdMux[ST_OSC]      = oscStatus;
        rdMux[ST_PLL_LOCK] = pllStab.stable;
      end
      OFS_IRQ_STAT: rdMux[IRQ_W-1:0] = irqStat_r;
      OFS_IRQ_MASK: rdMux[IRQ_W-1:0] = irqMask_r;
      OFS_POWER:
      begin
        rdMux[PW_WAIT] = waitMode;
        rdMux[PW_STOP] = stopMode;
      end
      default:      rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end
    else if (doRead)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rdMux;
      rresp_r  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_self_run_reset: assert property (selfSet |=> pllMult_r == PLL_A_RST)
    else $error("self-run select did not reset the multiplier");
  chk_pll_frozen_hold: assert property (pllFrozen |=> $stable(pllMult_r))
    else $error("multiplier changed while a clock was stopped");
  chk_periph_div_field: assert property (wrPmodeC && clkUnlock
    |=> periphDivide == $past(newPmodeC[PM_PDIV_LSB +: DIV_W]))
    else $error("peripheral divide did not take the written field");
  chk_one_power_mode: assert property (!(waitMode && stopMode)
    && (waitMode || stopMode || pmode_r == PM_NORMAL))
    else $error("power mode is not exactly one of three");
  chk_periph_locked: assert property (wrPmodeC && !clkUnlock |=> $stable(pmodeC_r))
    else $error("locked peripheral divide register was written");
  chk_pll_guard: assert property (wrPllA && srcCtrl_r[CS_SRC] && !selfSet
    |=> $stable(pllMult_r))
    else $error("multiplier written without the pll source selected");
  chk_osc_disable_bit: assert property (wrCtrlA && newCtrlA[CA_OSC_DIS]
    |=> !mainOscEnable)
    else $error("main oscillator not disabled by its bit");
  chk_clock_out_low: assert property (coutSel == COUT_LOW && $stable(coutSel)
    |=> clockOut == $past(lowClkSync))
    else $error("clock output does not follow the low-speed clock");
  chk_osc_status_stop: assert property (!mainRunSync |=> oscStatus [*2])
    else $error("oscillation status cleared while the main clock is stopped");
endmodule
`default_nettype wire

// ---- common/cgc_pkg.sv ----
`default_nettype none
package cgc_pkg;
  // bus geometry
  localparam int              ADDR_W        = 8;
  localparam int              DATA_W        = 32;
  localparam logic [1:0]      RESP_OKAY     = 2'h0;
  localparam logic [1:0]      RESP_SLVERR   = 2'h2;

  // register byte offsets
  localparam logic [7:0]      OFS_CTRL_A    = 8'h00;
  localparam logic [7:0]      OFS_CTRL_B    = 8'h04;
  localparam logic [7:0]      OFS_SRC_CTRL  = 8'h08;
  localparam logic [7:0]      OFS_PMODE_C   = 8'h0C;
  localparam logic [7:0]      OFS_WPROT     = 8'h10;
  localparam logic [7:0]      OFS_PLL_B     = 8'h14;
  localparam logic [7:0]      OFS_PLL_A     = 8'h18;
  localparam logic [7:0]      OFS_STATUS    = 8'h1C;
  localparam logic [7:0]      OFS_IRQ_STAT  = 8'h20;
  localparam logic [7:0]      OFS_IRQ_MASK  = 8'h24;
  localparam logic [7:0]      OFS_POWER     = 8'h28;

  // system_clock_ctrl_a fields
  localparam int              CA_OSC_DIS    = 0;
  localparam int              CA_COUT_LSB   = 1;
  localparam int              COUT_W        = 2;
  localparam logic [1:0]      COUT_OFF      = 2'h0;
  localparam logic [1:0]      COUT_LOW      = 2'h1;
  // system_clock_ctrl_b fields
  localparam int              CB_PLL_EN     = 0;
  localparam int              CB_BCS        = 1;
  localparam int              CB_LS_SEL     = 2;
  // clock_source_ctrl fields
  localparam int              CS_BDIV_LSB   = 0;
  localparam int              DIV_W         = 2;
  localparam int              CS_SRC        = 7;
  // processor_mode_reg_c fields
  localparam int              PM_PDIV_LSB   = 5;
  // write_protect_reg fields
  localparam int              WP_CLK        = 0;
  localparam int              WP_PLL        = 27;
  // pll_control_reg_b / a fields
  localparam int              PB_SELF       = 0;
  localparam int              MULT_W        = 8;
  // status and event bits
  localparam int              ST_OSC        = 0;
  localparam int              ST_PLL_LOCK   = 1;
  localparam int              IRQ_W         = 2;
  localparam int              EV_OSC_STOP   = 0;
  localparam int              EV_OSC_READY  = 1;
  // power control request bits
  localparam int              PW_WAIT       = 0;
  localparam int              PW_STOP       = 1;

  // reset values
  localparam logic [31:0]     CTRL_A_RST    = 32'h0000_0000;
  localparam logic [31:0]     CTRL_B_RST    = 32'h0000_0000;
  localparam logic [31:0]     SRC_CTRL_RST  = 32'h0000_0080;
  localparam logic [31:0]     PMODE_C_RST   = 32'h0000_0000;
  localparam logic [31:0]     WPROT_RST     = 32'h0000_0000;
  localparam logic [MULT_W-1:0] PLL_A_RST   = 8'h01;

  // oscillator settle time
  localparam int              CLK_PERIOD_NS = 10;
  localparam int              SETTLE_NS     = 2000;
  localparam int              SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {PM_NORMAL, PM_WAIT, PM_STOP} cgc_pmode_t;
endpackage
`default_nettype wire

// ---- common/cgc_stab_if.sv ----
`default_nettype none
interface cgc_stab_if;
  logic level;
  logic stable;
  modport timer (input level, output stable);
  modport user (output level, input stable);
endinterface
`default_nettype wire

// ---- src/cgc_stab_timer.sv ----
`default_nettype none
module cgc_stab_timer #(
  parameter int CYCLES = cgc_pkg::SETTLE_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // level watched and settled flag
  cgc_stab_if.timer       port
);
  import cgc_pkg::*;
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_END = CNT_W'(CYCLES);

  if (CYCLES < 1)
  begin : g_bad
    $error("settle count must be at least one cycle");
  end

  logic [CNT_W-1:0] count_r;
  wire              atEnd = (count_r == CNT_END);

  // any drop restarts the wait, so a glitching oscillator never reads settled
  always_ff @(posedge clock)
  begin
    if (sys_rst || !port.level)
      count_r <= '0;
    else if (!atEnd)
      count_r <= count_r + CNT_W'(1);
  end

  assign port.stable = atEnd;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_settle_drop: assert property (!port.level |=> !port.stable)
    else $error("settled flag survived a drop of the level");
endmodule
`default_nettype wire

// ---- tb/cgc_top_bench.sv ----
`default_nettype none
module cgc_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import cgc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  logic        clock = 1'h0;
  logic        sys_rst = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, baseDivide, periphDivide, resp;
  logic        mainOscRunning = 1'h1, pllLocked = 1'h1, lowSpeedClk = 1'h0;
  logic        wakeRequest = 1'h0;
  logic        mainOscEnable, pllEnable, pllSelfRun, baseClockSourceSelect, lowSpeedSelect;
  logic        pllSourceSelected, clockOut, waitMode, stopMode, irq;
  logic [7:0]  pllMultiplier, mult;
  logic [31:0] rdv, rnd;
  int          failCount = 0, checks = 0, cycles = 0;
  int          model[int];
  ////////////////////////////////////////////////////////////////////////////
  // short settle keeps the oscillator recovery scenario brief
  cgc_top #(.SETTLE(4)) u_cgc_top (.clock(clock), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mainOscRunning(mainOscRunning),
    .pllLocked(pllLocked), .lowSpeedClk(lowSpeedClk), .wakeRequest(wakeRequest),
    .mainOscEnable(mainOscEnable), .pllEnable(pllEnable), .pllSelfRun(pllSelfRun),
    .pllMultiplier(pllMultiplier), .baseDivide(baseDivide), .periphDivide(periphDivide),
    .baseClockSourceSelect(baseClockSourceSelect), .lowSpeedSelect(lowSpeedSelect),
    .pllSourceSelected(pllSourceSelected), .clockOut(clockOut), .waitMode(waitMode),
    .stopMode(stopMode), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 clock = ~clock;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failCount++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // each channel released at its own handshake edge; extra edge avoids re-entry races
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge clock);
  endtask

  task automatic rdc(input string what, input int a);
    rd(a[7:0]);
    check(what, rdv, model[a]);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rnd = $urandom(32'hB4AE3CC2);
    repeat (5) @(posedge clock);
    sys_rst <= 1'h0;
    repeat (20) @(posedge clock);
    model[OFS_CTRL_A] = CTRL_A_RST;
    model[OFS_CTRL_B] = CTRL_B_RST;
    model[OFS_SRC_CTRL] = SRC_CTRL_RST;
    model[OFS_PMODE_C] = PMODE_C_RST;
    model[OFS_WPROT] = WPROT_RST;
    model[OFS_PLL_A] = 32'(PLL_A_RST);
    foreach (model[k]) rdc("reset value", k);
    check("main osc enable", mainOscEnable, 1);
    rd(8'h3C);
    check("unmapped read", resp, RESP_SLVERR);
    wr(8'h3C, 32'h1);
    check("unmapped write", resp, RESP_SLVERR);
    wr(OFS_CTRL_A, 32'h1);
    check("main osc disabled", mainOscEnable, 0);
    wr(OFS_CTRL_A, 32'h0);
    wr(OFS_CTRL_B, 32'h1);
    model[OFS_CTRL_B] = 1;
    check("pll enable", pllEnable, 1);
    rnd = $urandom();
    wr(OFS_SRC_CTRL, rnd & 32'h3);
    model[OFS_SRC_CTRL] = rnd & 32'h3;
    rdc("source ctrl", OFS_SRC_CTRL);
    check("base divide", baseDivide, rnd & 32'h3);
    check("pll source", pllSourceSelected, 1);
    // locked write must be dropped silently
    wr(OFS_PMODE_C, 32'h60);
    rdc("locked periph div", OFS_PMODE_C);
    check("locked periph port", periphDivide, 0);
    wr(OFS_WPROT, 32'h1);
    wr(OFS_PMODE_C, 32'h60);
    model[OFS_PMODE_C] = 32'h60;
    rdc("periph div", OFS_PMODE_C);
    check("periph port", periphDivide, 3);
    wr(OFS_WPROT, 32'h0800_0001);
    mult = 8'($urandom()) | 8'h02;
    wr(OFS_PLL_A, 32'(mult));
    check("pll mult", pllMultiplier, mult);
    wr(OFS_PLL_B, 32'h1);
    model[OFS_PLL_A] = 1;
    check("self run", pllSelfRun, 1);
    rdc("mult after self run", OFS_PLL_A);
    // pll source deselected: the multiplier write must be ignored
    wr(OFS_SRC_CTRL, 32'h80 | (rnd & 32'h3));
    check("pll source off", pllSourceSelected, 0);
    wr(OFS_PLL_A, 32'h33);
    rdc("guarded mult", OFS_PLL_A);
    wr(OFS_SRC_CTRL, rnd & 32'h3);
    mainOscRunning <= 1'h0;
    wr(OFS_CTRL_A, 32'h1);
    check("osc held off", mainOscEnable, 0);
    repeat (6) @(posedge clock);
    rd(OFS_STATUS);
    check("osc status stopped", rdv, 32'h3);
    wr(OFS_PLL_A, 32'h55);
    rdc("frozen mult", OFS_PLL_A);
    wr(OFS_CTRL_A, 32'h0);
    mainOscRunning <= 1'h1;
    repeat (20) @(posedge clock);
    rd(OFS_STATUS);
    check("osc status settled", rdv, 32'h2);
    rd(OFS_IRQ_STAT);
    check("events", rdv, 3);
    wr(OFS_IRQ_MASK, 32'h1);
    check("irq unmasked", irq, 1);
    wr(OFS_IRQ_STAT, 32'h1);
    check("irq cleared", irq, 0);
    wr(OFS_IRQ_MASK, 32'h3);
    check("irq second", irq, 1);
    wr(OFS_IRQ_STAT, 32'h2);
    check("irq all clear", irq, 0);
    // output select 01 passes the low-speed clock, 00 holds low
    wr(OFS_CTRL_A, 32'(COUT_LOW) << CA_COUT_LSB);
    lowSpeedClk <= 1'h1;
    repeat (5) @(posedge clock);
    check("clock out high", clockOut, 1);
    lowSpeedClk <= 1'h0;
    repeat (5) @(posedge clock);
    check("clock out low", clockOut, 0);
    lowSpeedClk <= 1'h1;
    wr(OFS_CTRL_A, 32'h0);
    repeat (5) @(posedge clock);
    check("clock out off", clockOut, 0);
    // low-speed source first, base clock source select after it
    wr(OFS_CTRL_B, 32'h5);
    check("low speed select", lowSpeedSelect, 1);
    check("base source still main", baseClockSourceSelect, 0);
    wr(OFS_CTRL_B, 32'h7);
    model[OFS_CTRL_B] = 7;
    check("base source select", baseClockSourceSelect, 1);
    rdc("clock ctrl b", OFS_CTRL_B);
    for (int m = 1; m < 4; m++)
    begin
      wr(OFS_POWER, m);
      repeat (2) @(posedge clock);
      check("power mode", {stopMode, waitMode}, (m == 1) ? 2'h1 : 2'h2);
      wakeRequest <= 1'h1;
      repeat (5) @(posedge clock);
      check("normal mode", {stopMode, waitMode}, 0);
      wakeRequest <= 1'h0;
      repeat (3) @(posedge clock);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
